// file: rtl/pdmrx_fifo.sv
`timescale 1ns/1ps
module pdmrx_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop)
      begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + (push ? 1 : 0) - (pop ? 1 : 0));
    end
  end
endmodule

// file: rtl/pdmrx_pkg.sv
// Behaviour
// - default: left bit on falling clock edge, right bit on rising edge
// - edge swap input exchanges capture edges of left and right
// - each bitstream has its own decimation filter giving signed 16-bit samples
// - output rate is bit clock divided by 64 or 80 per ratio select
// - per-channel gain stage spans -20 dB to +20 dB around default
// - one gain code step is 0.5 dB
// - stereo words hold right in upper half, left in lower half
// - mono words hold two left samples, earlier one in lower half
// - samples are stored little-endian
// - sample count counts 16-bit samples; buffer bytes are twice that
// - stop waits for the frame in progress, then stopped event
// - pointer is double-buffered; writes after started apply to next buffer
// - full buffer raises end, switches to latched pointer, raises started
// - device generates the bit clock, frequency from its frequency field
// - bit clock derived from system clock edges only, adding no jitter
// - 16-bit samples at nominal 16 kHz output rate
// - two microphones share one data line, split by clock edge
package pdmrx_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned OUT_RATE_HZ  = 16_000;
  localparam int unsigned RATIO_LO     = 64;
  localparam int unsigned RATIO_HI     = 80;
  localparam logic [7:0]  BIT_CLOCK_FREQUENCY_RST     = 8'h14;
  localparam logic [6:0]  GAIN_DEFAULT = 7'h28;
  localparam logic [6:0]  GAIN_MIN     = 7'h00;
  localparam logic [6:0]  GAIN_MAX     = 7'h50;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned CNT_W        = 15;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned CIC_W        = 24;

  typedef struct packed {
    logic [15:0] right;
    logic [15:0] left;
  } pdmrx_pair_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
  } pdmrx_wr_t;
endpackage

// file: rtl/pdmrx_top.sv
`timescale 1ns/1ps
module pdmrx_top
  import pdmrx_pkg::*;
#(
  parameter int unsigned FIFO_W = 64
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              start_task,
  input  wire logic              stop_task,
  input  wire logic              edge_swap_select,
  input  wire logic              mono_select,
  input  wire logic              decimation_ratio_select,
  input  wire logic [7:0]        bit_clock_frequency,
  input  wire logic [6:0]        left_gain,
  input  wire logic [6:0]        right_gain,
  input  wire logic [ADDR_W-1:0] buffer_pointer,
  input  wire logic              buffer_pointer_write,
  input  wire logic [CNT_W-1:0]  buffer_sample_count,
  input  wire logic              pdm_data_in,
  output logic                   pdm_bit_clock,
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic [ADDR_W-1:0]      mem_wr_addr,
  output logic [31:0]            mem_wr_data,
  output logic                   event_started,
  output logic                   event_end,
  output logic                   event_stopped,
  output logic                   busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_STOP = 3'b100
  } pdmrx_state_t;

  // scaled gain: multiplier ~ 2^(code/12) approximated by table of 0.5 dB steps
  function automatic logic [15:0] pdmrx_gain_mul(input logic [6:0] code);
    logic [6:0]  c;
    logic [15:0] base [12];
    logic [3:0]  oct;
    logic [3:0]  idx;
    c = (code > GAIN_MAX) ? GAIN_MAX : code;
    base = '{16'h0100, 16'h010F, 16'h011F, 16'h0130, 16'h0143, 16'h0156,
             16'h016A, 16'h0180, 16'h0196, 16'h01AE, 16'h01C8, 16'h01E3};
    oct = 4'(c / 7'd12);
    idx = 4'(c % 7'd12);
    pdmrx_gain_mul = 16'(base[idx] << oct);
  endfunction

  function automatic logic [15:0] pdmrx_sat16(input logic signed [31:0] v);
    if (v > 32'sd32767)
      pdmrx_sat16 = 16'h7FFF;
    else if (v < -32'sd32768)
      pdmrx_sat16 = 16'h8000;
    else
      pdmrx_sat16 = v[15:0];
  endfunction

  // bit clock: half period in whole system clocks, no fractional jitter added
  logic [7:0] div_q;
  logic       run_clk_q;
  logic       rise_q;
  logic       fall_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q         <= '0;
      pdm_bit_clock <= 1'b0;
      rise_q        <= 1'b0;
      fall_q        <= 1'b0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (!run_clk_q)
      begin
        div_q         <= '0;
        pdm_bit_clock <= 1'b0;
      end
      else if (div_q >= ((bit_clock_frequency == '0) ? 8'h00 : bit_clock_frequency - 8'h01))
      begin
        div_q         <= '0;
        pdm_bit_clock <= !pdm_bit_clock;
        rise_q        <= !pdm_bit_clock;
        fall_q        <= pdm_bit_clock;
      end
      else
      begin
        div_q <= 8'(div_q + 8'h01);
      end
    end
  end

  // data pin synchroniser; the pin value taken is the one at the edge that
  // toggles the bit clock, before the microphone can drive the other channel
  logic din_s1_q;
  logic din_s2_q;
  logic rise_d1_q;
  logic fall_d1_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      din_s1_q  <= 1'b0;
      din_s2_q  <= 1'b0;
      rise_d1_q <= 1'b0;
      fall_d1_q <= 1'b0;
    end
    else
    begin
      din_s1_q  <= pdm_data_in;
      din_s2_q  <= din_s1_q;
      rise_d1_q <= rise_q;
      fall_d1_q <= fall_q;
    end
  end

  logic take_l;
  logic take_r;
  assign take_l = edge_swap_select ? rise_d1_q : fall_d1_q;
  assign take_r = edge_swap_select ? fall_d1_q : rise_d1_q;

  // second order CIC per channel, decimate on the left channel bit count
  logic signed [CIC_W-1:0] int1_q [2];
  logic signed [CIC_W-1:0] int2_q [2];
  logic signed [CIC_W-1:0] comb1_q [2];
  logic signed [CIC_W-1:0] comb2_q [2];
  logic signed [15:0]      pcm_q [2];
  logic [6:0]              bit_cnt_q;
  logic                    dec_q;
  logic [6:0]              ratio;
  assign ratio = decimation_ratio_select ? 7'(RATIO_HI) : 7'(RATIO_LO);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_cnt_q <= '0;
      dec_q     <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        int1_q[i]  <= '0;
        int2_q[i]  <= '0;
        comb1_q[i] <= '0;
        comb2_q[i] <= '0;
        pcm_q[i]   <= '0;
      end
    end
    else
    begin
      dec_q <= 1'b0;
      if (!run_clk_q)
      begin
        bit_cnt_q <= '0;
      end
      for (int i = 0; i < 2; i++)
      begin
        if ((i == 0) ? take_l : take_r)
        begin
          int1_q[i] <= CIC_W'(int1_q[i] + (din_s2_q ? 1 : -1));
          int2_q[i] <= CIC_W'(int2_q[i] + int1_q[i]);
        end
      end
      if (take_l && run_clk_q)
      begin
        if (bit_cnt_q == 7'(ratio - 7'd1))
        begin
          bit_cnt_q <= '0;
          dec_q     <= 1'b1;
          for (int i = 0; i < 2; i++)
          begin
            comb1_q[i] <= int2_q[i];
            comb2_q[i] <= CIC_W'(int2_q[i] - comb1_q[i]);
            // shift by 2 gives gain 4*R^2, full scale near 16 bits for either ratio
            pcm_q[i]   <= 16'(CIC_W'((int2_q[i] - comb1_q[i]) - comb2_q[i]) <<< 2);
          end
        end
        else
        begin
          bit_cnt_q <= 7'(bit_cnt_q + 7'd1);
        end
      end
    end
  end

  // volume stage, default code gives about +2 dB
  logic              scaled_q;
  pdmrx_pair_t       pair_q;
  logic signed [31:0] prod_l;
  logic signed [31:0] prod_r;
  assign prod_l = 32'((32'(signed'(pcm_q[0])) * signed'({1'b0, pdmrx_gain_mul(left_gain)}))
                  >>> 11);
  assign prod_r = 32'((32'(signed'(pcm_q[1])) * signed'({1'b0, pdmrx_gain_mul(right_gain)}))
                  >>> 11);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scaled_q <= 1'b0;
      pair_q   <= '0;
    end
    else
    begin
      scaled_q    <= dec_q;
      if (dec_q)
      begin
        pair_q.left  <= pdmrx_sat16(prod_l);
        pair_q.right <= pdmrx_sat16(prod_r);
      end
    end
  end

  // packing and buffer addressing
  pdmrx_state_t      state_q;
  logic [ADDR_W-1:0] ptr_next_q;
  logic [ADDR_W-1:0] addr_q;
  logic [CNT_W-1:0]  done_q;
  logic [15:0]       mono_lo_q;
  logic              mono_half_q;
  logic              stop_req_q;
  pdmrx_wr_t         wr_in;
  logic              wr_valid;
  logic              fifo_ready;
  logic              word_last;
  logic [CNT_W-1:0]  done_inc;
  logic              q_valid;
  pdmrx_wr_t         q_data;
  logic              out_take;
  assign done_inc  = CNT_W'(done_q + CNT_W'(2));
  assign word_last = done_inc >= buffer_sample_count;
  assign wr_valid  = scaled_q && (state_q != ST_IDLE) && (!mono_select || mono_half_q);
  assign wr_in.addr = addr_q;
  assign wr_in.data = mono_select ? {pair_q.left, mono_lo_q}
                                  : {pair_q.right, pair_q.left};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr_next_q <= '0;
    end
    else if (buffer_pointer_write)
    begin
      ptr_next_q <= buffer_pointer;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q       <= ST_IDLE;
      addr_q        <= '0;
      done_q        <= '0;
      mono_lo_q     <= '0;
      mono_half_q   <= 1'b0;
      stop_req_q    <= 1'b0;
      run_clk_q     <= 1'b0;
      event_started <= 1'b0;
      event_end     <= 1'b0;
    end
    else
    begin
      event_started <= 1'b0;
      event_end     <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_task)
          begin
            state_q       <= ST_RUN;
            addr_q        <= buffer_pointer_write ? buffer_pointer : ptr_next_q;
            done_q        <= '0;
            mono_half_q   <= 1'b0;
            stop_req_q    <= 1'b0;
            run_clk_q     <= 1'b1;
            event_started <= 1'b1;
          end
        end
        ST_RUN:
        begin
          if (stop_task)
          begin
            stop_req_q <= 1'b1;
          end
          if (scaled_q && mono_select && !mono_half_q)
          begin
            mono_lo_q   <= pair_q.left;
            mono_half_q <= 1'b1;
          end
          if (wr_valid && fifo_ready)
          begin
            mono_half_q <= 1'b0;
            addr_q      <= ADDR_W'(addr_q + ADDR_W'(4));
            done_q      <= done_inc;
            if (word_last)
            begin
              event_end <= 1'b1;
              done_q    <= '0;
              addr_q    <= ptr_next_q;
              if (stop_req_q || stop_task)
              begin
                state_q   <= ST_STOP;
                run_clk_q <= 1'b0;
              end
              else
              begin
                event_started <= 1'b1;
              end
            end
            else if (stop_req_q || stop_task)
            begin
              event_end <= 1'b1;
              state_q   <= ST_STOP;
              run_clk_q <= 1'b0;
            end
          end
        end
        ST_STOP:
        begin
          // the last word may still sit in the queue while the output is empty
          if (!mem_wr_valid && !q_valid)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // stopped only after the write queue has drained
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      event_stopped <= 1'b0;
      busy          <= 1'b0;
    end
    else
    begin
      event_stopped <= (state_q == ST_STOP) && !mem_wr_valid && !q_valid;
      busy          <= state_q != ST_IDLE;
    end
  end

  assign out_take = !mem_wr_valid || mem_wr_ready;

  pdmrx_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (wr_valid && (state_q == ST_RUN)),
    .in_ready  (fifo_ready),
    .in_data   (wr_in),
    .out_valid (q_valid),
    .out_ready (out_take),
    .out_data  (q_data)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_wr_valid <= 1'b0;
      mem_wr_addr  <= '0;
      mem_wr_data  <= '0;
    end
    else if (out_take)
    begin
      mem_wr_valid <= q_valid;
      if (q_valid)
      begin
        mem_wr_addr <= q_data.addr;
        mem_wr_data <= q_data.data;
      end
    end
  end
endmodule

// file: testbench/pdmrx_mic_model.sv
`timescale 1ns/1ps
module pdmrx_mic_model (
  input  wire logic pdm_bit_clock,
  output logic      pdm_data_in
);
  logic [1:0] ph_q = 2'h0;
  always @(posedge pdm_bit_clock)
    ph_q <= ph_q + 2'h1;
  // left drives while clock high, right while low; delay stands in for output valid time
  assign #10 pdm_data_in = pdm_bit_clock ? (ph_q != 2'h0) : (ph_q == 2'h0);
endmodule

// file: testbench/pdmrx_top_monitor.sv
`timescale 1ns/1ps
module pdmrx_top_monitor
  import pdmrx_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              start_task,
  input wire logic              stop_task,
  input wire logic [7:0]        bit_clock_frequency,
  input wire logic              pdm_bit_clock,
  input wire logic              mem_wr_valid,
  input wire logic              mem_wr_ready,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic [CNT_W-1:0]  buffer_sample_count,
  input wire logic              event_started,
  input wire logic              event_end,
  input wire logic              event_stopped,
  input wire logic              busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic              acc;
  logic [ADDR_W-1:0] last_q;
  logic [CNT_W-1:0]  wcnt_q;
  logic [CNT_W-1:0]  wper;
  logic              stop_q;
  logic [7:0]        cnt_q;
  logic              seen_q;
  assign acc = mem_wr_valid && mem_wr_ready;
  // words per buffer; the first word of each buffer jumps to the new pointer
  assign wper = CNT_W'(({1'b0, buffer_sample_count} + 16'h0001) >> 1);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_q <= '0;
      wcnt_q <= '0;
      stop_q <= 1'b0;
      cnt_q  <= 8'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      if (acc)
        last_q <= mem_wr_addr;
      if (start_task && !busy)
        wcnt_q <= '0;
      else if (acc)
        wcnt_q <= (wcnt_q + 15'h0001 >= wper) ? '0 : CNT_W'(wcnt_q + 15'h0001);
      stop_q <= stop_task || (stop_q && !(start_task && !busy));
      cnt_q  <= $changed(pdm_bit_clock) ? 8'h00 : cnt_q + 8'h01;
      // first rise after start has no full period behind it
      seen_q <= busy && (seen_q || $rose(pdm_bit_clock));
    end
  end
  hold_words_a: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr)) else $error("write changed before ready");
  addr_step_a: assert property (acc && wcnt_q != '0 |->
    mem_wr_addr == last_q + 32'h4) else $error("word address not consecutive");
  start_event_a: assert property (start_task && !busy |=> event_started)
    else $error("no started after start");
  stop_quiet_a: assert property (event_stopped |->
    !mem_wr_valid ##1 !mem_wr_valid [*3]) else $error("write after stopped");
  idle_quiet_a: assert property (!busy && !$past(busy) |->
    !mem_wr_valid && !event_end && !pdm_bit_clock) else $error("activity while idle");
  end_restart_a: assert property (event_end && !stop_q |-> ##[0:2] event_started)
    else $error("no started after end");
  end_pulse_a: assert property (event_end |=> !event_end)
    else $error("end longer than one cycle");
  bitclk_half_a: assert property (seen_q && $rose(pdm_bit_clock) &&
    $stable(bit_clock_frequency) |-> cnt_q == bit_clock_frequency - 8'h01)
    else $error("bit clock half period wrong");
endmodule
bind pdmrx_top pdmrx_top_monitor pdmrx_top_monitor_i (.clk(clk), .reset_n(reset_n),
  .start_task(start_task), .stop_task(stop_task), .bit_clock_frequency(bit_clock_frequency),
  .pdm_bit_clock(pdm_bit_clock), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
  .mem_wr_addr(mem_wr_addr), .buffer_sample_count(buffer_sample_count),
  .event_started(event_started), .event_end(event_end),
  .event_stopped(event_stopped), .busy(busy));

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pdmrx_pkg::*;
  localparam logic [31:0] P0 = 32'h20000000;
  localparam logic [31:0] P1 = 32'h20000100;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              start_task = 1'b0;
  logic              stop_task = 1'b0;
  logic              edge_swap_select = 1'b0;
  logic              mono_select = 1'b0;
  logic              decimation_ratio_select = 1'b0;
  logic [7:0]        bit_clock_frequency = 8'h04;
  logic [6:0]        left_gain = GAIN_DEFAULT;
  logic [6:0]        right_gain = GAIN_DEFAULT;
  logic [ADDR_W-1:0] buffer_pointer = P0;
  logic              buffer_pointer_write = 1'b0;
  logic [CNT_W-1:0]  buffer_sample_count = 15'h0008;
  logic              pdm_data_in;
  logic              pdm_bit_clock;
  logic              mem_wr_valid;
  logic              mem_wr_ready = 1'b1;
  logic [ADDR_W-1:0] mem_wr_addr;
  logic [31:0]       mem_wr_data;
  logic              event_started;
  logic              event_end;
  logic              event_stopped;
  logic              busy;
  logic [31:0]       wa[$];
  logic [31:0]       wd[$];
  logic [31:0]       wt[$];
  logic [31:0]       cyc = 32'h0;
  int                mismatches = 0;
  int                tests_run = 0;

  pdmrx_top pdmrx_top_i (.clk(clk), .reset_n(reset_n), .start_task(start_task),
    .stop_task(stop_task), .edge_swap_select(edge_swap_select), .mono_select(mono_select),
    .decimation_ratio_select(decimation_ratio_select), .bit_clock_frequency(bit_clock_frequency),
    .left_gain(left_gain), .right_gain(right_gain), .buffer_pointer(buffer_pointer),
    .buffer_pointer_write(buffer_pointer_write), .buffer_sample_count(buffer_sample_count),
    .pdm_data_in(pdm_data_in), .pdm_bit_clock(pdm_bit_clock), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .event_started(event_started), .event_end(event_end), .event_stopped(event_stopped),
    .busy(busy));
  pdmrx_mic_model pdmrx_mic_model_i (.pdm_bit_clock(pdm_bit_clock), .pdm_data_in(pdm_data_in));

  initial
    forever #12.5 clk = ~clk;

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // memory side: records accepted words with their cycle
  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
    begin
      wa.push_back(mem_wr_addr);
      wd.push_back(mem_wr_data);
      wt.push_back(cyc);
    end
    if (cyc == 32'h00015F90)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // word 5 is well past filter settling, so its sign is trusted
  task automatic run(input logic sw, mo, ra, input logic [6:0] gl, gr, input int st,
                     input logic lp, rp, bg);
    int                 i;
    logic signed [19:0] lv;
    logic signed [19:0] rv;
    logic [31:0]        per;
    edge_swap_select <= sw;
    mono_select <= mo;
    decimation_ratio_select <= ra;
    left_gain <= gl;
    right_gain <= gr;
    buffer_pointer <= P0;
    buffer_pointer_write <= 1'b1;
    mem_wr_ready <= (st == 0);
    wa.delete();
    wd.delete();
    wt.delete();
    @(posedge clk);
    buffer_pointer_write <= 1'b0;
    start_task <= 1'b1;
    @(posedge clk);
    start_task <= 1'b0;
    @(posedge clk);
    chk_b(event_started, 1'b1);
    buffer_pointer <= P1;
    buffer_pointer_write <= 1'b1;
    @(posedge clk);
    buffer_pointer_write <= 1'b0;
    repeat (st) @(posedge clk);
    mem_wr_ready <= 1'b1;
    for (i = 0; i < 20000 && wa.size() < 7; i++)
      @(posedge clk);
    stop_task <= 1'b1;
    @(posedge clk);
    stop_task <= 1'b0;
    for (i = 0; i < 8000 && event_stopped !== 1'b1; i++)
      @(posedge clk);
    chk_b(event_stopped, 1'b1);
    repeat (4) @(posedge clk);
    chk_b(busy, 1'b0);
    chk_b(pdm_bit_clock, 1'b0);
    for (i = 0; i < 7; i++)
      chk_v(wa[i], (i < 4) ? P0 + 32'(4 * i) : P1 + 32'(4 * (i - 4)));
    lv = $signed(wd[5][15:0]);
    rv = $signed(wd[5][31:16]);
    chk_b(lv > 20'sh0, lp);
    chk_b(rv > 20'sh0, rp);
    if (bg)
      chk_b(lv > -(rv <<< 3), 1'b1);
    per = 32'(2 * bit_clock_frequency * (ra ? RATIO_HI : RATIO_LO) * (mo ? 2 : 1));
    chk_v(wt[6] - wt[5], per);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_b(pdm_bit_clock, 1'b0);
    // long stall at the start queues two words in the buffer path before draining
    run(1'b0, 1'b0, 1'b0, GAIN_DEFAULT, GAIN_DEFAULT, 1200, 1'b1, 1'b0, 1'b0);
    run(1'b1, 1'b0, 1'b0, GAIN_DEFAULT, GAIN_DEFAULT, 0, 1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b0, GAIN_DEFAULT, GAIN_DEFAULT, 0, 1'b1, 1'b1, 1'b0);
    // a second half period shows the divider follows its setting
    bit_clock_frequency <= 8'h05;
    run(1'b0, 1'b0, 1'b1, GAIN_DEFAULT, GAIN_DEFAULT, 0, 1'b1, 1'b0, 1'b0);
    run(1'b0, 1'b0, 1'b0, GAIN_MAX, GAIN_MIN, 0, 1'b1, 1'b0, 1'b1);
    wrap_up();
  end
endmodule
